// *** hw/svr_pkg.sv ***
// package for the spindle / voice-coil control register bank
// assumes a serial port front end that delivers whole 12-bit writes
package svr_pkg;

    // ==========================================================
    // register addresses and widths
    localparam int REG_W = 12;
    localparam int ADDR_W = 4;
    localparam logic [3:0] ADDR_VOICE_COIL = 4'h1;
    localparam logic [3:0] ADDR_SPIN_CTL = 4'h2;
    localparam logic [3:0] ADDR_SYS_CTL_A = 4'h3;

    // ==========================================================
    // reset values
    localparam logic [11:0] RST_VOICE_COIL = 12'h000;
    localparam logic [11:0] RST_SPIN_CTL = 12'h000;
    localparam logic [11:0] RST_SYS_CTL_A = 12'h000;

    // ==========================================================
    // voice-coil register fields
    localparam int VC_MAG_LSB = 0;
    localparam int VC_MAG_W = 10;
    localparam int VC_SIGN_BIT = 10;
    localparam int VC_GAIN_BIT = 11;
    localparam logic [9:0] VC_MAG_FULL = 10'h3ff;

    // ==========================================================
    // spin control fields
    localparam int SP_DAC_LSB = 0;
    localparam int SP_DAC_W = 8;
    localparam int SP_DLY_LSB = 8;
    localparam int SP_DLY_W = 4;
    localparam logic [3:0] SP_DLY_MIN = 4'h1;

    // ==========================================================
    // system control A bit positions
    localparam int CA_SPIN_EN = 0;
    localparam int CA_ACT_EN = 1;
    localparam int CA_SEQ_RST = 2;
    localparam int CA_STEP = 3;
    localparam int CA_AUTO = 4;
    localparam int CA_POLE = 5;
    localparam int CA_DRV_HI = 6;
    localparam int CA_DRV_LO = 7;
    localparam int CA_RETRACT = 8;
    localparam int CA_SPEED = 9;
    localparam int CA_CYCLE = 10;
    localparam int CA_TEST = 11;

    // ==========================================================
    // types
    typedef enum logic [1:0] {
        SVR_SLEEP = 2'b00,
        SVR_PARK = 2'b01,
        SVR_NORMAL = 2'b11,
        SVR_IDLE = 2'b10
    } svr_mode_e;

    typedef enum logic [1:0] {
        SVR_TRISTATE = 2'b00,
        SVR_UNDEFINED = 2'b01,
        SVR_TRIPOLAR = 2'b11,
        SVR_BIPOLAR = 2'b10
    } svr_drive_e;

    typedef struct packed {
        logic valid;
        logic [3:0] addr;
        logic [11:0] data;
    } svr_wr_s;

endpackage

// *** hw/svr_regs.sv ***
// write-only control registers of the spindle / voice-coil combo
// assumes WR comes from serial logic on CLK, valid only for whole writes
//
// Overview of operation
// - coil DAC magnitude is ten bits, bit 0 least significant
// - bit 10 sets the voice-coil current direction
// - bit 11 picks coarse resistor alone or coarse plus fine
// - negative entries negate; 0x400 saturates to 0x3ff; gain independent
// - spin bits 0-7 set spindle current limit and at-speed preset
// - spin bits 8-11 set commutation delay in 1.875 degree steps
// - bits 0 and 1 enable spindle and actuator, selecting mode
// - bit 2 low resets sequencer and loop; high turns pump off
// - rising bit 3 steps the spindle state machine once
// - bit 4 high selects run mode, low search mode
// - bit 5 high selects 8 poles, low 12 poles
// - bits 6 and 7 select tristate, bipolar or tripolar drive
// - bit 8 high commands actuator retract
// - bit 9 low open loop speed, high internal loop
// - bit 10 high electrical cycle, low mechanical cycle
// - bit 11 low clears test sequence; high enables test pins
// - 00 sleep, actuator only park, spindle only idle, both normal
// - drive code 00 tristate, 01 undefined, 10 bipolar, 11 tripolar
// - during undervoltage registers held cleared except delay held at 1, writes ignored
`timescale 1ns/1ns
module svr_regs #(
    parameter int DATA_W = 12
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_B,
    // supply monitor, low while under voltage
    input wire logic UNDERVOLTAGE_FLAG_B,
    // completed serial writes
    input wire svr_pkg::svr_wr_s WR,
    // voice-coil drive
    output logic [9:0] COIL_DAC_MAGNITUDE,
    output logic COIL_CURRENT_SIGN,
    output logic COIL_RANGE_SELECT,
    // spindle drive
    output logic [7:0] SPINDLE_DAC,
    output logic [3:0] COMMUTATION_DELAY,
    // system control
    output svr_pkg::svr_mode_e OPERATING_MODE,
    output logic SPINDLE_ENABLE,
    output logic ACTUATOR_ENABLE,
    output logic SEQUENCER_RESET_B,
    output logic CHARGE_PUMP_OFF,
    output logic STEP_ADVANCE_PULSE,
    output logic AUTO_ADVANCE_SELECT,
    output logic POLE_COUNT_SELECT,
    output svr_pkg::svr_drive_e DRIVE_MODE,
    output logic ACTUATOR_RETRACT,
    output logic CLOSED_LOOP_SPEED,
    output logic CYCLE_BASIS_SELECT,
    output logic TEST_SEQ_CLEAR_B
);

    // ==========================================================
    // elaboration check
    if (DATA_W != svr_pkg::REG_W)
    begin : g_bad_width
        $error("svr_regs: register width must be 12");
    end

    // ==========================================================
    // helpers
    function automatic logic hit(input svr_pkg::svr_wr_s w, input logic [3:0] a);
        hit = w.valid && (w.addr == a);
    endfunction

    function automatic logic [9:0] coil_mag(input logic [11:0] d);
        logic [9:0] raw;
        raw = d[svr_pkg::VC_MAG_LSB +: svr_pkg::VC_MAG_W];
        if (!d[svr_pkg::VC_SIGN_BIT])
        begin
            coil_mag = raw;
        end
        else if (raw == 10'h000)
        begin
            coil_mag = svr_pkg::VC_MAG_FULL;
        end
        else
        begin
            coil_mag = 10'(~raw + 10'h001);
        end
    endfunction

    // ==========================================================
    // undervoltage synchroniser
    logic uv_meta;
    logic uv_ok;

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            uv_meta <= 1'b0;
            uv_ok <= 1'b0;
        end
        else
        begin
            uv_meta <= UNDERVOLTAGE_FLAG_B;
            uv_ok <= uv_meta;
        end
    end

    // ==========================================================
    // voice-coil register
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            COIL_DAC_MAGNITUDE <= svr_pkg::RST_VOICE_COIL[9:0];
            COIL_CURRENT_SIGN <= svr_pkg::RST_VOICE_COIL[svr_pkg::VC_SIGN_BIT];
            COIL_RANGE_SELECT <= svr_pkg::RST_VOICE_COIL[svr_pkg::VC_GAIN_BIT];
        end
        else if (!uv_ok)
        begin
            COIL_DAC_MAGNITUDE <= svr_pkg::RST_VOICE_COIL[9:0];
            COIL_CURRENT_SIGN <= svr_pkg::RST_VOICE_COIL[svr_pkg::VC_SIGN_BIT];
            COIL_RANGE_SELECT <= svr_pkg::RST_VOICE_COIL[svr_pkg::VC_GAIN_BIT];
        end
        else if (hit(WR, svr_pkg::ADDR_VOICE_COIL))
        begin
            COIL_DAC_MAGNITUDE <= coil_mag(WR.data);
            COIL_CURRENT_SIGN <= WR.data[svr_pkg::VC_SIGN_BIT];
            COIL_RANGE_SELECT <= WR.data[svr_pkg::VC_GAIN_BIT];
        end
    end

    // ==========================================================
    // spin control register
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            SPINDLE_DAC <= svr_pkg::RST_SPIN_CTL[7:0];
            COMMUTATION_DELAY <= svr_pkg::SP_DLY_MIN;
        end
        else if (!uv_ok)
        begin
            SPINDLE_DAC <= svr_pkg::RST_SPIN_CTL[7:0];
            COMMUTATION_DELAY <= svr_pkg::SP_DLY_MIN;
        end
        else if (hit(WR, svr_pkg::ADDR_SPIN_CTL))
        begin
            SPINDLE_DAC <= WR.data[svr_pkg::SP_DAC_LSB +: svr_pkg::SP_DAC_W];
            if (WR.data[svr_pkg::SP_DLY_LSB +: svr_pkg::SP_DLY_W] == 4'h0)
            begin
                COMMUTATION_DELAY <= svr_pkg::SP_DLY_MIN;
            end
            else
            begin
                COMMUTATION_DELAY <= WR.data[svr_pkg::SP_DLY_LSB +: svr_pkg::SP_DLY_W];
            end
        end
    end

    // ==========================================================
    // system control A register
    logic step_level;
    logic ctl_hit;
    assign ctl_hit = hit(WR, svr_pkg::ADDR_SYS_CTL_A);

    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            OPERATING_MODE <= svr_pkg::SVR_SLEEP;
            SPINDLE_ENABLE <= 1'b0;
            ACTUATOR_ENABLE <= 1'b0;
            SEQUENCER_RESET_B <= 1'b0;
            CHARGE_PUMP_OFF <= 1'b0;
            step_level <= 1'b0;
            AUTO_ADVANCE_SELECT <= 1'b0;
            POLE_COUNT_SELECT <= 1'b0;
            DRIVE_MODE <= svr_pkg::SVR_TRISTATE;
            ACTUATOR_RETRACT <= 1'b0;
            CLOSED_LOOP_SPEED <= 1'b0;
            CYCLE_BASIS_SELECT <= 1'b0;
            TEST_SEQ_CLEAR_B <= 1'b0;
        end
        else if (!uv_ok)
        begin
            OPERATING_MODE <= svr_pkg::SVR_SLEEP;
            SPINDLE_ENABLE <= 1'b0;
            ACTUATOR_ENABLE <= 1'b0;
            SEQUENCER_RESET_B <= 1'b0;
            CHARGE_PUMP_OFF <= 1'b0;
            step_level <= 1'b0;
            AUTO_ADVANCE_SELECT <= 1'b0;
            POLE_COUNT_SELECT <= 1'b0;
            DRIVE_MODE <= svr_pkg::SVR_TRISTATE;
            ACTUATOR_RETRACT <= 1'b0;
            CLOSED_LOOP_SPEED <= 1'b0;
            CYCLE_BASIS_SELECT <= 1'b0;
            TEST_SEQ_CLEAR_B <= 1'b0;
        end
        else if (ctl_hit)
        begin
            // enables map onto the mode codes directly
            OPERATING_MODE <= svr_pkg::svr_mode_e'({WR.data[svr_pkg::CA_SPIN_EN],
                WR.data[svr_pkg::CA_ACT_EN]});
            SPINDLE_ENABLE <= WR.data[svr_pkg::CA_SPIN_EN];
            ACTUATOR_ENABLE <= WR.data[svr_pkg::CA_ACT_EN];
            SEQUENCER_RESET_B <= WR.data[svr_pkg::CA_SEQ_RST];
            CHARGE_PUMP_OFF <= WR.data[svr_pkg::CA_SEQ_RST];
            step_level <= WR.data[svr_pkg::CA_STEP];
            AUTO_ADVANCE_SELECT <= WR.data[svr_pkg::CA_AUTO];
            POLE_COUNT_SELECT <= WR.data[svr_pkg::CA_POLE];
            DRIVE_MODE <= svr_pkg::svr_drive_e'({WR.data[svr_pkg::CA_DRV_HI],
                WR.data[svr_pkg::CA_DRV_LO]});
            ACTUATOR_RETRACT <= WR.data[svr_pkg::CA_RETRACT];
            CLOSED_LOOP_SPEED <= WR.data[svr_pkg::CA_SPEED];
            CYCLE_BASIS_SELECT <= WR.data[svr_pkg::CA_CYCLE];
            TEST_SEQ_CLEAR_B <= WR.data[svr_pkg::CA_TEST];
        end
    end

    // ==========================================================
    // one-cycle step on a written 0 to 1 of the step bit
    always_ff @(posedge CLK or negedge RST_B)
    begin
        if (!RST_B)
        begin
            STEP_ADVANCE_PULSE <= 1'b0;
        end
        else
        begin
            STEP_ADVANCE_PULSE <= uv_ok && ctl_hit && !step_level
                && WR.data[svr_pkg::CA_STEP];
        end
    end

    // ==========================================================
    // checks
    property p_mag_pos;
        @(posedge CLK) disable iff (!RST_B)
        (uv_ok && hit(WR, svr_pkg::ADDR_VOICE_COIL) && !WR.data[10])
        |=> COIL_DAC_MAGNITUDE == $past(WR.data[9:0]);
    endproperty
    a_mag_pos: assert property (p_mag_pos) else $error("coil magnitude wrong");

    property p_sign;
        @(posedge CLK) disable iff (!RST_B)
        (uv_ok && hit(WR, svr_pkg::ADDR_VOICE_COIL))
        |=> COIL_CURRENT_SIGN == $past(WR.data[10]);
    endproperty
    a_sign: assert property (p_sign) else $error("coil sign wrong");

    property p_gain;
        @(posedge CLK) disable iff (!RST_B)
        (uv_ok && hit(WR, svr_pkg::ADDR_VOICE_COIL))
        |=> COIL_RANGE_SELECT == $past(WR.data[11]);
    endproperty
    a_gain: assert property (p_gain) else $error("coil range wrong");

    property p_mag_neg;
        @(posedge CLK) disable iff (!RST_B)
        (uv_ok && hit(WR, svr_pkg::ADDR_VOICE_COIL) && WR.data[10])
        |=> (COIL_DAC_MAGNITUDE + $past(WR.data[9:0]) == 11'h400)
            || ($past(WR.data[9:0]) == 10'h000 && COIL_DAC_MAGNITUDE == 10'h3ff);
    endproperty
    a_mag_neg: assert property (p_mag_neg) else $error("negative magnitude wrong");

    property p_spin_dac;
        @(posedge CLK) disable iff (!RST_B)
        (uv_ok && hit(WR, svr_pkg::ADDR_SPIN_CTL))
        |=> SPINDLE_DAC == $past(WR.data[7:0]);
    endproperty
    a_spin_dac: assert property (p_spin_dac) else $error("spindle dac wrong");

    property p_delay;
        @(posedge CLK) disable iff (!RST_B)
        (uv_ok && hit(WR, svr_pkg::ADDR_SPIN_CTL))
        |=> COMMUTATION_DELAY != 4'h0
            && (COMMUTATION_DELAY == $past(WR.data[11:8]) || $past(WR.data[11:8]) == 4'h0);
    endproperty
    a_delay: assert property (p_delay) else $error("commutation delay wrong");

    property p_mode;
        @(posedge CLK) disable iff (!RST_B)
        1'b1 |-> (OPERATING_MODE == svr_pkg::SVR_NORMAL) == (SPINDLE_ENABLE && ACTUATOR_ENABLE)
            && (OPERATING_MODE == svr_pkg::SVR_PARK) == (!SPINDLE_ENABLE && ACTUATOR_ENABLE);
    endproperty
    a_mode: assert property (p_mode) else $error("mode disagrees with enables");

    property p_step;
        @(posedge CLK) disable iff (!RST_B)
        (uv_ok && ctl_hit && !step_level && WR.data[3])
        |=> STEP_ADVANCE_PULSE ##1 (!STEP_ADVANCE_PULSE || $past(ctl_hit));
    endproperty
    a_step: assert property (p_step) else $error("step pulse wrong");

    property p_drive;
        @(posedge CLK) disable iff (!RST_B)
        (uv_ok && ctl_hit && WR.data[7:6] == 2'b01)
        |=> DRIVE_MODE == svr_pkg::SVR_BIPOLAR;
    endproperty
    a_drive: assert property (p_drive) else $error("drive mode wrong");

    property p_uv;
        @(posedge CLK) disable iff (!RST_B)
        !uv_ok |=> COIL_DAC_MAGNITUDE == 10'h000 && SPINDLE_DAC == 8'h00
            && !SEQUENCER_RESET_B && !STEP_ADVANCE_PULSE;
    endproperty
    a_uv: assert property (p_uv) else $error("write took effect under voltage");

    property p_hold;
        @(posedge CLK) disable iff (!RST_B)
        (uv_ok && !hit(WR, svr_pkg::ADDR_SPIN_CTL))
        |=> $stable(SPINDLE_DAC) && $stable(COMMUTATION_DELAY);
    endproperty
    a_hold: assert property (p_hold) else $error("spin register changed unwritten");

endmodule

// *** tb/svr_host_model.sv ***
// host processor model: issues whole 12-bit register writes
// assumes the bank samples WR on the rising edge of CLK
`timescale 1ns/1ns
module svr_host_model (
    // clock
    input wire logic CLK,
    // write port toward the register bank
    output svr_pkg::svr_wr_s WR
);
    initial WR = '0;

    // ==========================================================
    // bus cycles
    // released lines show the inverse, never a stale copy
    task automatic write(input logic [3:0] addr, input logic [11:0] data);
        @(posedge CLK);
        WR <= {1'b1, addr, data};
        @(posedge CLK);
        WR <= {1'b0, ~addr, ~data};
    endtask

    // signed current packed as 11-bit two's complement plus range bit
    task automatic coil(input int cur, input logic rng);
        logic [31:0] c;
        c = cur;
        write(svr_pkg::ADDR_VOICE_COIL, {rng, c[10:0]});
    endtask
endmodule

// *** tb/svr_regs_bench.sv ***
// self-checking bench for the control register bank
// assumes svr_host_model drives the write port
`timescale 1ns/1ns
`define CHK(got, exp) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            fails++; \
            $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); \
        end \
    end
module svr_regs_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic uv_b = 1'b1;
    svr_pkg::svr_wr_s wr;
    logic [9:0] mag;
    logic sgn, rng, spen, acen, seq_b, pump, step, auto, pole, retr, spd, cyc, tst_b;
    logic [7:0] sdac;
    logic [3:0] dly;
    svr_pkg::svr_mode_e mode;
    svr_pkg::svr_drive_e drv;
    int fails = 0;
    int n_tests = 0;
    logic prev3;

    always #25 clk = ~clk;

    svr_host_model svr_host_model_i (.CLK(clk), .WR(wr));

    svr_regs #(.DATA_W(12)) svr_regs_i (
        .CLK(clk), .RST_B(rst_b), .UNDERVOLTAGE_FLAG_B(uv_b), .WR(wr),
        .COIL_DAC_MAGNITUDE(mag), .COIL_CURRENT_SIGN(sgn), .COIL_RANGE_SELECT(rng),
        .SPINDLE_DAC(sdac), .COMMUTATION_DELAY(dly), .OPERATING_MODE(mode),
        .SPINDLE_ENABLE(spen), .ACTUATOR_ENABLE(acen), .SEQUENCER_RESET_B(seq_b),
        .CHARGE_PUMP_OFF(pump), .STEP_ADVANCE_PULSE(step), .AUTO_ADVANCE_SELECT(auto),
        .POLE_COUNT_SELECT(pole), .DRIVE_MODE(drv), .ACTUATOR_RETRACT(retr),
        .CLOSED_LOOP_SPEED(spd), .CYCLE_BASIS_SELECT(cyc), .TEST_SEQ_CLEAR_B(tst_b)
    );

    // ==========================================================
    // scenarios
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_cleared;
        `CHK(mag, 10'h000)
        `CHK({sgn, rng, sdac}, 10'h000)
        `CHK(dly, 4'h1)
        `CHK(mode, svr_pkg::SVR_SLEEP)
        `CHK({seq_b, pump, step, retr, tst_b}, 5'h00)
    endtask

    task automatic t_coil;
        int cur[7] = '{0, 0, 1023, -1024, -1023, -1, 1};
        logic rg[7] = '{0, 1, 0, 0, 0, 0, 0};
        logic [9:0] em[7] = '{10'h000, 10'h000, 10'h3ff, 10'h3ff, 10'h3ff, 10'h001, 10'h001};
        logic es[7] = '{0, 0, 0, 1, 1, 1, 0};
        for (int i = 0; i < 7; i++)
        begin
            svr_host_model_i.coil(cur[i], rg[i]);
            #1;
            `CHK(mag, em[i])
            `CHK(sgn, es[i])
            `CHK(rng, rg[i])
        end
        $display("test coil done");
    endtask

    task automatic t_spin;
        logic [3:0] codes[4] = '{4'h0, 4'h1, 4'hf, 4'h7};
        for (int i = 0; i < 4; i++)
        begin
            svr_host_model_i.write(svr_pkg::ADDR_SPIN_CTL, {codes[i], codes[i], ~codes[i]});
            #1;
            `CHK(sdac, {codes[i], ~codes[i]})
            `CHK(dly, (codes[i] == 4'h0) ? 4'h1 : codes[i])
        end
        $display("test spin done");
    endtask

    task automatic t_ctl;
        svr_pkg::svr_mode_e md[4] = '{svr_pkg::SVR_SLEEP, svr_pkg::SVR_IDLE,
            svr_pkg::SVR_PARK, svr_pkg::SVR_NORMAL};
        svr_pkg::svr_drive_e dm[4] = '{svr_pkg::SVR_TRISTATE, svr_pkg::SVR_UNDEFINED,
            svr_pkg::SVR_BIPOLAR, svr_pkg::SVR_TRIPOLAR};
        logic [11:0] d;
        logic [1:0] k;
        prev3 = 1'b0;
        for (int i = 0; i < 4; i++)
        begin
            k = i[1:0];
            d = k[0] ? 12'h518 : 12'ha34;
            d[1:0] = k;
            d[7:6] = ~k;
            svr_host_model_i.write(svr_pkg::ADDR_SYS_CTL_A, d);
            #1;
            `CHK({spen, acen}, {d[0], d[1]})
            `CHK(mode, md[d[1:0]])
            `CHK({seq_b, pump}, {d[2], d[2]})
            `CHK(step, d[3] & ~prev3)
            `CHK({auto, pole}, {d[4], d[5]})
            `CHK(drv, dm[{d[6], d[7]}])
            `CHK({tst_b, cyc, spd, retr}, d[11:8])
            prev3 = d[3];
            wait_cyc(1);
            `CHK(step, 1'b0)
        end
        `CHK(mag, 10'h001)
        `CHK(sdac, 8'h78)
        $display("test ctl done");
    endtask

    task automatic t_unmapped;
        svr_host_model_i.write(4'h0, 12'hfff);
        svr_host_model_i.write(4'h4, 12'hfff);
        svr_host_model_i.write(4'hf, 12'hfff);
        #1;
        `CHK({mag, sgn, rng}, 12'h004)
        `CHK({sdac, dly}, 12'h787)
        `CHK({tst_b, spen, retr}, 3'b011)
        $display("test unmapped done");
    endtask

    task automatic t_uv;
        @(posedge clk);
        uv_b <= 1'b0;
        wait_cyc(3);
        t_cleared();
        svr_host_model_i.write(svr_pkg::ADDR_SYS_CTL_A, 12'h00f);
        #1;
        `CHK({spen, step}, 2'b00)
        @(posedge clk);
        uv_b <= 1'b1;
        wait_cyc(3);
        svr_host_model_i.write(svr_pkg::ADDR_SYS_CTL_A, 12'h008);
        #1;
        `CHK(step, 1'b1)
        svr_host_model_i.write(svr_pkg::ADDR_SYS_CTL_A, 12'h008);
        #1;
        `CHK(step, 1'b0)
        $display("test undervoltage done");
    endtask

    // ==========================================================
    // sequence and verdict
    task automatic results;
        $display("comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        wait_cyc(3);
        t_cleared();
        $display("test reset done");
        t_coil();
        t_spin();
        t_ctl();
        t_unmapped();
        t_uv();
        results();
    end

    initial
    begin
        #(5000 * 50);
        fails++;
        results();
    end
endmodule
